// ---- logic/sfr_pkg.sv ----
// Constants and types for the discoverable-parameter table
package sfr_pkg;
	// Serial command and framing
	localparam logic [7:0]  CMD_PARAM_READ = 8'h5A;
	localparam logic [4:0]  ADDR_BITS      = 5'h18;
	localparam logic [4:0]  DUMMY_CLKS     = 5'h08;
	localparam logic [4:0]  BYTE_LAST_BIT  = 5'h07;
	localparam logic [23:0] ADDR_STEP      = 24'h000001;
	// Placement of the basic block inside the parameter space
	localparam logic [23:0] BLOCK_BASE     = 24'h000030;
	localparam logic [23:0] BLOCK_BYTES    = 24'h000018;
	localparam logic [7:0]  FILL_BYTE      = 8'hFF;
	// Register offsets
	localparam logic [23:0] OFS_ERASE_CAPS = 24'h000030;
	localparam logic [23:0] OFS_DENSITY    = 24'h000034;
	localparam logic [23:0] OFS_QUAD_READS = 24'h000038;
	localparam logic [23:0] OFS_DUAL_READS = 24'h00003C;
	localparam logic [23:0] OFS_WIDE_CAPS  = 24'h000040;
	localparam logic [23:0] OFS_TWO_LINE   = 24'h000044;
	// Bytes 30h and 31h fields
	localparam logic [2:0]  UNUSED_ONES3   = 3'h7;
	localparam logic [1:0]  STATUS_WR_05   = 2'h0;
	localparam logic        BUF_OVER_64    = 1'b1;
	localparam logic [1:0]  ERASE_UNIFORM  = 2'h1;
	localparam logic [7:0]  ERASE_4K_CODE  = 8'h20;
	// Byte 32h fields
	localparam logic        READ_114_OK    = 1'b1;
	localparam logic        READ_144_OK    = 1'b1;
	localparam logic        READ_122_OK    = 1'b1;
	localparam logic        DTR_OK         = 1'b1;
	localparam logic [1:0]  ADDR_3B_ONLY   = 2'h0;
	localparam logic        SINGLE_DUAL_OK = 1'b1;
	// Array density, bits minus one
	localparam logic [31:0] DENSITY_M1     = 32'h07FFFFFF;
	// Read mode descriptors: mode cycles, dummy cycles, instruction
	localparam logic [2:0]  QUAD_IO_MODE   = 3'h2;
	localparam logic [4:0]  QUAD_IO_DUMMY  = 5'h04;
	localparam logic [7:0]  QUAD_IO_CODE   = 8'hEB;
	localparam logic [2:0]  QUAD_OUT_MODE  = 3'h0;
	localparam logic [4:0]  QUAD_OUT_DUMMY = 5'h08;
	localparam logic [7:0]  QUAD_OUT_CODE  = 8'h6B;
	localparam logic [2:0]  DOR_MODE       = 3'h0;
	localparam logic [4:0]  DOR_DUMMY      = 5'h08;
	localparam logic [7:0]  DOR_CODE       = 8'h3B;
	localparam logic [2:0]  DUAL_IO_MODE   = 3'h4;
	localparam logic [4:0]  DUAL_IO_DUMMY  = 5'h00;
	localparam logic [7:0]  DUAL_IO_CODE   = 8'hBB;
	// Byte 40h fields, plus a 16-bit all-ones fill
	localparam logic        FOUR_LINE_OK   = 1'b1;
	localparam logic        DUAL_ALL_OK    = 1'b0;
	localparam logic [15:0] ALL_ONES16     = 16'hFFFF;

	// Sequencer states
	typedef enum logic [5:0] {
		SFR_IDLE   = 6'h01,
		SFR_CMD    = 6'h02,
		SFR_ADDR   = 6'h04,
		SFR_DUMMY  = 6'h08,
		SFR_DATA   = 6'h10,
		SFR_IGNORE = 6'h20
	} sfr_state_t;

	// Sampled serial pins
	typedef struct packed {
		logic sck;
		logic cs_b;
		logic si;
	} sfr_pins_t;
endpackage

// ---- logic/sfr_rom.sv ----
// Serial parameter-read front end and fixed basic parameter table
//
// Contract
// R01 - Command 5Ah reads parameter space from zero
// R02 - Basic block starts at byte 30h
// R03 - Uniform 4 KB erase, code 20h
// R04 - Program buffer over 64 bytes; unused ones
// R05 - Status write form 05h, non-volatile default
// R06 - Three-byte addressing only
// R07 - DTR and single/dual support advertised
// R08 - 1-1-4, 1-4-4, 1-2-2 advertised; byte F9h
// R09 - Density 07FFFFFFh, little-endian
// R10 - 1-4-4 read EBh, mode 010b, dummy 00100b
// R11 - 1-1-4 read 6Bh, no mode, dummy 01000b
// R12 - 1-1-2 read 3Bh, no mode, dummy 01000b
// R13 - 1-2-2 read BBh, mode 100b, dummy 0
// R14 - Four-line fast read supported; reserved ones
// R15 - Two-line-all unsupported; its fields ones
// R16 - Unused bytes read FFh
// R17 - Fixed contents; reads ascend byte by byte
`timescale 1ns/1ps
`default_nettype none
module sfr_rom
	import sfr_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic sck,
	input  wire logic cs_b,
	input  wire logic si,
	output var  logic so_out,
	output var  logic so_oe
);

	// R16 - Fill elsewhere
	// R17 - Constant table
	function automatic logic [7:0] rom_byte(input logic [23:0] a);
		logic [23:0] rel;
		logic [31:0] dw;
		rel = a - BLOCK_BASE;
		dw  = {32{1'b1}};
		// R02 - Block offset window
		if (a < BLOCK_BASE || rel >= BLOCK_BYTES) begin
			rom_byte = FILL_BYTE;
		end else begin
			unique case (a & ~24'h000003)
				// R03 - Erase caps
				// R04 - Buffer flag
				// R05 - Status form
				// R06 - Address bytes
				// R07 - DTR flags
				// R08 - Read formats
				OFS_ERASE_CAPS: dw = {FILL_BYTE, 1'b1, READ_114_OK, READ_144_OK,
					READ_122_OK, DTR_OK, ADDR_3B_ONLY, SINGLE_DUAL_OK,
					ERASE_4K_CODE, UNUSED_ONES3, STATUS_WR_05, BUF_OVER_64,
					ERASE_UNIFORM};
				// R09 - Density word
				OFS_DENSITY:    dw = DENSITY_M1;
				// R10 - Quad io
				// R11 - Quad output
				OFS_QUAD_READS: dw = {QUAD_OUT_CODE, QUAD_OUT_MODE, QUAD_OUT_DUMMY,
					QUAD_IO_CODE, QUAD_IO_MODE, QUAD_IO_DUMMY};
				// R12 - Dual output
				// R13 - Dual io
				OFS_DUAL_READS: dw = {DUAL_IO_CODE, DUAL_IO_MODE, DUAL_IO_DUMMY,
					DOR_CODE, DOR_MODE, DOR_DUMMY};
				// R14 - Four-line flag
				OFS_WIDE_CAPS:  dw = {ALL_ONES16, FILL_BYTE, UNUSED_ONES3,
					FOUR_LINE_OK, UNUSED_ONES3, DUAL_ALL_OK};
				// R15 - Dual all ones
				OFS_TWO_LINE:   dw = {ALL_ONES16, ALL_ONES16};
				default:        dw = {32{1'b1}};
			endcase
			// R09 - Little-endian lanes
			unique case (rel[1:0])
				2'h0:    rom_byte = dw[7:0];
				2'h1:    rom_byte = dw[15:8];
				2'h2:    rom_byte = dw[23:16];
				default: rom_byte = dw[31:24];
			endcase
		end
	endfunction

	// Pin sampling; pins are synchronous so one stage gives edge history
	sfr_pins_t pins_reg;
	sfr_pins_t pins_next;
	logic      sck_rise;
	logic      sck_fall;

	always_comb begin
		pins_next = '{sck: sck, cs_b: cs_b, si: si};
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pins_reg <= '{sck: 1'b0, cs_b: 1'b1, si: 1'b0};
		end else begin
			pins_reg <= pins_next;
		end
	end

	assign sck_rise = sck & ~pins_reg.sck;
	assign sck_fall = ~sck & pins_reg.sck;

	// Sequencer state
	sfr_state_t  state_reg;
	sfr_state_t  state_next;
	logic [4:0]  cnt_reg;
	logic [4:0]  cnt_next;
	logic [23:0] shift_reg;
	logic [23:0] shift_next;
	logic [23:0] addr_reg;
	logic [23:0] addr_next;
	logic [7:0]  byte_reg;
	logic [7:0]  byte_next;
	logic        so_next;
	logic        oe_next;
	logic [23:0] shifted;

	// Sample on rising, drive on falling (clock mode 0)
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		addr_next  = addr_reg;
		byte_next  = byte_reg;
		so_next    = so_out;
		oe_next    = so_oe;
		shifted    = {shift_reg[22:0], si};
		if (cs_b) begin
			// Deselect aborts any frame at once
			state_next = SFR_IDLE;
			cnt_next   = '0;
			oe_next    = 1'b0;
		end else begin
			unique case (state_reg)
				SFR_IDLE: begin
					state_next = SFR_CMD;
					cnt_next   = '0;
				end
				SFR_CMD: if (sck_rise) begin
					shift_next = shifted;
					cnt_next   = cnt_reg + 5'h01;
					if (cnt_reg == BYTE_LAST_BIT) begin
						cnt_next = '0;
						// R01 - Command match
						if (shifted[7:0] == CMD_PARAM_READ) begin
							state_next = SFR_ADDR;
						end else begin
							state_next = SFR_IGNORE;
						end
					end
				end
				SFR_ADDR: if (sck_rise) begin
					shift_next = shifted;
					cnt_next   = cnt_reg + 5'h01;
					// R06 - Exactly three bytes
					if (cnt_reg == ADDR_BITS - 5'h01) begin
						cnt_next   = '0;
						addr_next  = shifted;
						state_next = SFR_DUMMY;
					end
				end
				SFR_DUMMY: if (sck_rise) begin
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == DUMMY_CLKS - 5'h01) begin
						cnt_next   = '0;
						byte_next  = rom_byte(addr_reg);
						state_next = SFR_DATA;
					end
				end
				SFR_DATA: if (sck_fall) begin
					so_next  = byte_reg[3'(BYTE_LAST_BIT - cnt_reg)];
					oe_next  = 1'b1;
					cnt_next = cnt_reg + 5'h01;
					// R17 - Ascending bytes
					if (cnt_reg == BYTE_LAST_BIT) begin
						cnt_next  = '0;
						addr_next = addr_reg + ADDR_STEP;
						byte_next = rom_byte(addr_reg + ADDR_STEP);
					end
				end
				SFR_IGNORE: begin
					// Foreign commands, writes included, change nothing here
					state_next = SFR_IGNORE;
				end
			endcase
		end
	end

	// Registers only; the table itself has no storage to write
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= SFR_IDLE;
			cnt_reg   <= '0;
			shift_reg <= '0;
			addr_reg  <= '0;
			byte_reg  <= FILL_BYTE;
			so_out    <= 1'b0;
			so_oe     <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			addr_reg  <= addr_next;
			byte_reg  <= byte_next;
			so_out    <= so_next;
			so_oe     <= oe_next;
		end
	end

	// Checks
	sequence s_cmd_last_bit;
		sck_rise && !cs_b && state_reg == SFR_CMD && cnt_reg == BYTE_LAST_BIT;
	endsequence

	property p_cmd_accept;
		@(posedge clk_sys) disable iff (!rst_b)
		s_cmd_last_bit ##0 ({shift_reg[6:0], si} == CMD_PARAM_READ)
			|=> state_reg == SFR_ADDR;
	endproperty
	a_cmd_accept: assert property (p_cmd_accept) else $error("read cmd not taken"); // R01

	property p_cmd_reject;
		@(posedge clk_sys) disable iff (!rst_b)
		s_cmd_last_bit ##0 ({shift_reg[6:0], si} != CMD_PARAM_READ)
			|=> state_reg == SFR_IGNORE;
	endproperty
	a_cmd_reject: assert property (p_cmd_reject) else $error("bad cmd accepted"); // R01

	property p_addr_len;
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(state_reg == SFR_DUMMY) |-> $past(cnt_reg) == ADDR_BITS - 5'h01;
	endproperty
	a_addr_len: assert property (p_addr_len) else $error("address not 24 bits"); // R06

	property p_block_base;
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(state_reg == SFR_DATA) && addr_reg == BLOCK_BASE
			|-> byte_reg[1:0] == ERASE_UNIFORM && byte_reg[2] == BUF_OVER_64
			&& byte_reg[4:3] == STATUS_WR_05 && byte_reg[7:5] == UNUSED_ONES3;
	endproperty
	a_block_base: assert property (p_block_base) else $error("erase caps wrong"); // R03

	property p_density;
		@(posedge clk_sys) disable iff (!rst_b)
		state_reg == SFR_DATA && addr_reg == OFS_DENSITY + 24'h000003
			|-> byte_reg == DENSITY_M1[31:24];
	endproperty
	a_density: assert property (p_density) else $error("density top byte wrong"); // R09

	property p_quad_io;
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(state_reg == SFR_DATA) && addr_reg == OFS_QUAD_READS
			|-> byte_reg == {QUAD_IO_MODE, QUAD_IO_DUMMY};
	endproperty
	a_quad_io: assert property (p_quad_io) else $error("quad io cycles wrong"); // R10

	property p_dual_io;
		@(posedge clk_sys) disable iff (!rst_b)
		state_reg == SFR_DATA && addr_reg == OFS_DUAL_READS + 24'h000003
			|-> byte_reg == DUAL_IO_CODE;
	endproperty
	a_dual_io: assert property (p_dual_io) else $error("dual io code wrong"); // R13

	property p_fill;
		@(posedge clk_sys) disable iff (!rst_b)
		state_reg == SFR_DATA && addr_reg == OFS_WIDE_CAPS + 24'h000001
			|-> byte_reg == FILL_BYTE;
	endproperty
	a_fill: assert property (p_fill) else $error("reserved byte not FFh"); // R16

	property p_ascend;
		@(posedge clk_sys) disable iff (!rst_b)
		sck_fall && !cs_b && state_reg == SFR_DATA && cnt_reg == BYTE_LAST_BIT
			|=> addr_reg == $past(addr_reg) + ADDR_STEP && cnt_reg == 5'h00;
	endproperty
	a_ascend: assert property (p_ascend) else $error("address did not step"); // R17

	property p_oe_frame;
		@(posedge clk_sys) disable iff (!rst_b)
		cs_b |=> !so_oe ##1 (!so_oe || !cs_b);
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("drive outside frame"); // R01

	// Rising select must drop the line and return the sequencer to idle next cycle
	property p_deselect;
		@(posedge clk_sys) disable iff (!rst_b)
		!pins_reg.cs_b && cs_b |=> state_reg == SFR_IDLE && !so_oe;
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect not seen"); // R01

	// Each address bit lands in the low end of the shifter
	property p_addr_shift;
		@(posedge clk_sys) disable iff (!rst_b)
		sck_rise && !cs_b && state_reg == SFR_ADDR |=> shift_reg[0] == pins_reg.si;
	endproperty
	a_addr_shift: assert property (p_addr_shift) else $error("address bit lost"); // R06

	// Byte lane checks hold for the whole time the byte is on the wire
	property p_quad_out;
		@(posedge clk_sys) disable iff (!rst_b)
		state_reg == SFR_DATA && addr_reg == OFS_QUAD_READS + 24'h000003
			|-> byte_reg == QUAD_OUT_CODE;
	endproperty
	a_quad_out: assert property (p_quad_out) else $error("quad out code wrong"); // R11

	property p_dual_out;
		@(posedge clk_sys) disable iff (!rst_b)
		state_reg == SFR_DATA && addr_reg == OFS_DUAL_READS + 24'h000001
			|-> byte_reg == DOR_CODE;
	endproperty
	a_dual_out: assert property (p_dual_out) else $error("dual out code wrong"); // R12

	property p_wide_caps;
		@(posedge clk_sys) disable iff (!rst_b)
		state_reg == SFR_DATA && addr_reg == OFS_WIDE_CAPS
			|-> byte_reg[4] == FOUR_LINE_OK && byte_reg[0] == DUAL_ALL_OK;
	endproperty
	a_wide_caps: assert property (p_wide_caps) else $error("wide caps flags wrong"); // R14

endmodule
`default_nettype wire

// ---- logic/sfr_unused_guard.sv ----
// Intentionally empty design unit list terminator
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verif/sfr_host_model.sv ----
// Host controller model that issues parameter reads on the serial pins
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
	input  wire logic clk_sys,
	input  wire logic so_out,
	input  wire logic so_oe,
	output var  logic sck,
	output var  logic cs_b,
	output var  logic si
);
	logic [7:0] got [32];
	logic       oe_any;
	logic       oe_all;

	// Mode 0 idle: clock parked low, device deselected
	initial begin
		sck  = 1'b0;
		cs_b = 1'b1;
		si   = 1'b0;
	end

	// One bit: high two clocks, low three; data taken just before the rise
	task automatic xfer(input logic b, output logic d);
		repeat (2) @(negedge clk_sys);
		sck <= 1'b0;
		si  <= b;
		repeat (3) @(negedge clk_sys);
		// A released line reads inverted so stale data cannot pass
		d      = so_oe ? so_out : ~so_out;
		oe_any = oe_any | so_oe;
		sck   <= 1'b1;
	endtask

	// One frame; nbits short of a whole byte models an abort
	task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int nbits);
		logic d;
		oe_any = 1'b0;
		oe_all = 1'b1;
		@(negedge clk_sys);
		cs_b <= 1'b0;
		for (int i = 0; i < 8; i++) xfer(cmd[7 - i], d);
		for (int i = 0; i < 24; i++) xfer(addr[23 - i], d);
		// Dummy and data clocks toggle the input so stale levels are not trusted
		for (int i = 0; i < 8; i++) xfer(~si, d);
		for (int i = 0; i < nbits; i++) begin
			xfer(~si, d);
			got[i / 8][7 - (i % 8)] = d;
			oe_all = oe_all & so_oe;
		end
		repeat (2) @(negedge clk_sys);
		sck <= 1'b0;
		@(negedge clk_sys);
		cs_b <= 1'b1;
		si   <= ~si;
		repeat (3) @(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ---- verif/sfr_rom_tb.sv ----
// Self-checking bench for the parameter table behind the serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module sfr_rom_tb;
	typedef struct packed {
		logic [23:0] ofs;
		logic [31:0] val;
	} sfr_row_t;

	logic clk_sys;
	logic rst_b;
	wire  sck;
	wire  cs_b;
	wire  si;
	wire  so_out;
	wire  so_oe;
	int   mismatches;
	int   samples_checked;
	logic [7:0] cmds [3] = '{8'h02, 8'h5B, 8'hA5};
	// Each double word as read back, byte 0 in the low bits
	sfr_row_t rows [6] = '{
		'{24'h000030, 32'hFFF920E5}, '{24'h000034, 32'h07FFFFFF},
		'{24'h000038, 32'h6B08EB44}, '{24'h00003C, 32'hBB803B08},
		'{24'h000040, 32'hFFFFFFFE}, '{24'h000044, 32'hFFFFFFFF}};

	sfr_rom dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
		.so_out(so_out), .so_oe(so_oe));
	sfr_host_model host_u (.clk_sys(clk_sys), .so_out(so_out), .so_oe(so_oe), .sck(sck),
		.cs_b(cs_b), .si(si));

	// Free-running system clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog so a stuck frame cannot hang the run
	initial begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end

	initial begin
		mismatches      = 0;
		samples_checked = 0;
		rst_b           = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		`CHK(so_oe, 1'b0)
		`CHK(so_out, 1'b0)
		repeat (2) @(negedge clk_sys);
		// Foreign commands, a write among them, must never drive the line
		foreach (cmds[c]) begin
			host_u.frame(cmds[c], 24'h000030, 16);
			`CHK(host_u.oe_any, 1'b0)
		end
		// Table rows: each double word read whole, contents still intact
		foreach (rows[r]) begin
			host_u.frame(8'h5A, rows[r].ofs, 32);
			`CHK({host_u.got[3], host_u.got[2], host_u.got[1], host_u.got[0]}, rows[r].val)
			`CHK(host_u.oe_all, 1'b1)
			`CHK(so_oe, 1'b0)
		end
		// Burst across both block edges, one byte each side
		host_u.frame(8'h5A, 24'h00002F, 208);
		`CHK(host_u.got[0], 8'hFF)
		for (int k = 0; k < 24; k++) begin
			`CHK(host_u.got[k + 1], rows[k / 4].val[8 * (k % 4) +: 8])
		end
		`CHK(host_u.got[25], 8'hFF)
		// Abort in mid-byte, then a clean read must still start correctly
		host_u.frame(8'h5A, 24'h000030, 12);
		`CHK(so_oe, 1'b0)
		host_u.frame(8'h5A, 24'h000034, 32);
		`CHK({host_u.got[3], host_u.got[2], host_u.got[1], host_u.got[0]}, 32'h07FFFFFF)
		// Second reset in mid-run, then the first double word again
		rst_b = 1'b0;
		@(negedge clk_sys);
		`CHK(so_oe, 1'b0)
		rst_b = 1'b1;
		repeat (2) @(negedge clk_sys);
		host_u.frame(8'h5A, 24'h000030, 32);
		`CHK({host_u.got[3], host_u.got[2], host_u.got[1], host_u.got[0]}, 32'hFFF920E5)
		end_of_test();
	end
endmodule
`undef CHK
`default_nettype wire
